// ### hdl/ihop_packer.sv
// intranet header packer: bit-packs fields into octets, then passes ip octets
module ihop_packer
  import ihop_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    start,
  input  wire logic [IHOP_VER_W-1:0]   version,
  input  wire logic [IHOP_MTYPE_W-1:0] msg_type,
  input  wire logic [IHOP_HLEN_W-1:0]  hdr_len,
  input  wire logic [IHOP_TOS_W-1:0]   tos,
  output logic                         busy,
  input  wire logic                    fld_valid,
  output logic                         fld_ready,
  input  wire ihop_field_s             fld,
  input  wire logic                    fld_last,
  input  wire logic                    ip_valid,
  output logic                         ip_ready,
  input  wire logic [IHOP_OCTET_W-1:0] ip_data,
  input  wire logic                    ip_last,
  output logic                         oct_valid,
  input  wire logic                    oct_ready,
  output ihop_octet_s                  oct,
  output logic                         oct_strobe
);
  typedef struct packed {
    ihop_state_e             state;
    logic [1:0]              hidx;
    logic [IHOP_ACC_W-1:0]   acc;
    logic [IHOP_FILL_W-1:0]  fill;
    logic [IHOP_NUM_W-1:0]   num;
    logic                    first;
    logic                    push;
    ihop_octet_s             word;
    logic                    strobe;
    logic                    busy;
    logic                    fld_rdy;
    logic                    ip_rdy;
    logic                    fld_on;
  } ihop_pk_s;

  ihop_pk_s    st_q;
  ihop_pk_s    st_d;
  logic        buf_ready;
  logic        buf_valid;
  ihop_octet_s buf_data;
  logic        valid_q;
  ihop_octet_s oct_q;

  ihop_skid_buffer u_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (st_q.push),
    .in_ready  (buf_ready),
    .in_data   (st_q.word),
    .out_valid (buf_valid),
    .out_ready (oct_ready && valid_q ? 1'b1 : !valid_q),
    .out_data  (buf_data)
  );

  // header field source: the four fixed header fields only; extra fields come in on fld
  ihop_field_s cur;
  logic        cur_ok;
  logic        cur_end;
  logic [IHOP_ACC_W-1:0] merged;
  logic [IHOP_ACC_W-1:0] mask;

  always_comb
  begin
    cur     = '0;
    cur_ok  = 1'b0;
    cur_end = 1'b0;
    case (st_q.hidx)
      2'h0:
      begin
        cur = '{value: 8'(version), width: 4'(IHOP_VER_W)};
        cur_ok = 1'b1;
      end
      2'h1:
      begin
        cur = '{value: 8'(msg_type), width: 4'(IHOP_MTYPE_W)};
        cur_ok = 1'b1;
      end
      2'h2:
      begin
        cur = '{value: hdr_len, width: 4'(IHOP_HLEN_W)};
        cur_ok = 1'b1;
      end
      2'h3:
      begin
        cur = '{value: tos, width: 4'(IHOP_TOS_W)};
        cur_ok = 1'b1;
        cur_end = 1'b0;
      end
      default:
      begin
        cur = '0;
      end
    endcase
  end

  always_comb
  begin
    mask = 16'((17'h00001 << fld.width) - 17'h00001);
    merged = 16'h0000;
    st_d = st_q;
    st_d.push = 1'b0;
    st_d.strobe = 1'b0;
    st_d.fld_rdy = 1'b0;
    st_d.ip_rdy = 1'b0;
    case (st_q.state)
      IHOP_ST_IDLE:
      begin
        // the last ip octet may still wait for a buffer slot
        if (st_q.push && !buf_ready)
          st_d.push = 1'b1;
        if (start)
        begin
          st_d.state = IHOP_ST_HDR;
          st_d.hidx = 2'h0;
          st_d.acc = 16'h0000;
          st_d.fill = IHOP_FILL_RST;
          st_d.num = IHOP_NUM_RST;
          st_d.first = 1'b1;
          st_d.busy = 1'b1;
        end
      end
      IHOP_ST_HDR:
      begin
        if (st_q.push && !buf_ready)
          st_d.push = 1'b1;
        else if (st_q.fill >= 5'(IHOP_OCTET_W))
        begin
          // emit the full low octet; leftover bits shift down
          st_d.word.data = st_q.acc[IHOP_OCTET_W-1:0];
          st_d.word.num = st_q.num;
          st_d.word.first = st_q.first;
          st_d.word.last = 1'b0;
          st_d.first = 1'b0;
          st_d.push = 1'b1;
          st_d.strobe = 1'b1;
          st_d.num = 16'(st_q.num + 16'h0001);
          st_d.acc = st_q.acc >> IHOP_OCTET_W;
          st_d.fill = 5'(st_q.fill - 5'(IHOP_OCTET_W));
        end
        else if (cur_ok && st_q.hidx != 2'h3 || st_q.fill == 5'h10)
        begin
          merged = 16'(16'(cur.value) << st_q.fill);
          st_d.acc = st_q.acc | merged;
          st_d.fill = 5'(st_q.fill + 5'(cur.width));
          st_d.hidx = 2'(st_q.hidx + 2'h1);
        end
        else if (st_q.hidx == 2'h3 && !cur_end)
        begin
          merged = 16'(16'(cur.value) << st_q.fill);
          st_d.acc = st_q.acc | merged;
          st_d.fill = 5'(st_q.fill + 5'(cur.width));
          st_d.hidx = 2'h0;
          st_d.state = IHOP_ST_PASS;
          // field ready follows once the tos octet has gone out
          st_d.fld_on = 1'b1;
        end
      end
      IHOP_ST_PASS:
      begin
        if (fld_valid && st_q.fld_rdy)
        begin
          // extra header fields with their own width; a pending push rides along
          merged = 16'((16'(fld.value) & mask) << st_q.fill);
          st_d.acc = st_q.acc | merged;
          st_d.fill = 5'(st_q.fill + 5'(fld.width));
          st_d.push = st_q.push && !buf_ready;
          st_d.fld_on = !fld_last;
          // ready again at once only if no full octet must go out first
          st_d.fld_rdy = !fld_last
                         && (5'(st_q.fill + 5'(fld.width)) < 5'(IHOP_OCTET_W));
        end
        else if (st_q.push && !buf_ready)
        begin
          st_d.push = 1'b1;
          st_d.fld_rdy = st_q.fld_rdy;
        end
        else if (st_q.fill >= 5'(IHOP_OCTET_W))
        begin
          st_d.word.data = st_q.acc[IHOP_OCTET_W-1:0];
          st_d.word.num = st_q.num;
          st_d.word.first = st_q.first;
          st_d.word.last = 1'b0;
          st_d.first = 1'b0;
          st_d.push = 1'b1;
          st_d.strobe = 1'b1;
          st_d.num = 16'(st_q.num + 16'h0001);
          st_d.fld_rdy = st_q.fld_on;
          st_d.acc = st_q.acc >> IHOP_OCTET_W;
          st_d.fill = 5'(st_q.fill - 5'(IHOP_OCTET_W));
        end
        else if (st_q.fld_on)
          st_d.fld_rdy = 1'b1;
        else if (st_q.fill != 5'h00)
        begin
          // pad a partial tail octet with zero bits
          st_d.fill = 5'(IHOP_OCTET_W);
        end
        else if (ip_valid && st_q.ip_rdy)
        begin
          st_d.word.data = ip_data;
          st_d.word.num = st_q.num;
          st_d.word.first = st_q.first;
          st_d.word.last = ip_last;
          st_d.first = 1'b0;
          st_d.push = 1'b1;
          st_d.num = 16'(st_q.num + 16'h0001);
          if (ip_last)
          begin
            st_d.state = IHOP_ST_IDLE;
            st_d.busy = 1'b0;
          end
        end
        else
          // no push pending here, so the octet offered next cycle is taken
          st_d.ip_rdy = 1'b1;
      end
      default:
      begin
        st_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q    <= '0;
      valid_q <= 1'b0;
      oct_q   <= '0;
    end
    else
    begin
      st_q <= st_d;
      if (!valid_q || oct_ready)
      begin
        valid_q <= buf_valid;
        oct_q   <= buf_data;
      end
    end
  end

  assign busy       = st_q.busy;
  assign fld_ready  = st_q.fld_rdy;
  assign ip_ready   = st_q.ip_rdy;
  assign oct_valid  = valid_q;
  assign oct        = oct_q;
  assign oct_strobe = st_q.strobe;
endmodule

// ### hdl/ihop_pkg.sv
// shared constants and carriers for the intranet header octet packer
package ihop_pkg;
  localparam int unsigned IHOP_FIELD_W  = 8;
  localparam int unsigned IHOP_WIDTH_W  = 4;
  localparam int unsigned IHOP_OCTET_W  = 8;
  localparam int unsigned IHOP_ACC_W    = 16;
  localparam int unsigned IHOP_FILL_W   = 5;
  localparam int unsigned IHOP_NUM_W    = 16;
  localparam int unsigned IHOP_VER_W    = 4;
  localparam int unsigned IHOP_MTYPE_W  = 4;
  localparam int unsigned IHOP_HLEN_W   = 8;
  localparam int unsigned IHOP_TOS_W    = 8;
  localparam int unsigned IHOP_HDR_OCTS = 3;
  localparam logic [IHOP_FILL_W-1:0] IHOP_FILL_RST = 5'h00;
  localparam logic [IHOP_NUM_W-1:0]  IHOP_NUM_RST  = 16'h0000;

  typedef enum logic [1:0] {
    IHOP_ST_IDLE = 2'h0,
    IHOP_ST_HDR  = 2'h1,
    IHOP_ST_PASS = 2'h3
  } ihop_state_e;

  // one field of up to eight bits with its width
  typedef struct packed {
    logic [IHOP_FIELD_W-1:0] value;
    logic [IHOP_WIDTH_W-1:0] width;
  } ihop_field_s;

  // one output octet with its running number and frame marks
  typedef struct packed {
    logic [IHOP_OCTET_W-1:0] data;
    logic [IHOP_NUM_W-1:0]   num;
    logic                    first;
    logic                    last;
  } ihop_octet_s;
endpackage

// ### hdl/ihop_skid_buffer.sv
// two-entry buffer for output octets
module ihop_skid_buffer
  import ihop_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire ihop_octet_s in_data,
  output logic             out_valid,
  input  wire logic        out_ready,
  output ihop_octet_s      out_data
);
  typedef struct packed {
    ihop_octet_s [1:0] mem;
    logic              rd;
    logic              wr;
    logic [1:0]        cnt;
  } ihop_buf_s;

  ihop_buf_s st_q;
  ihop_buf_s st_d;

  always_comb
  begin
    st_d = st_q;
    if (in_valid && st_q.cnt != 2'h2)
    begin
      st_d.mem[st_q.wr] = in_data;
      st_d.wr = ~st_q.wr;
    end
    if (out_ready && st_q.cnt != 2'h0)
      st_d.rd = ~st_q.rd;
    st_d.cnt = 2'(st_q.cnt + 2'((in_valid && st_q.cnt != 2'h2) ? 1 : 0)
                 - 2'((out_ready && st_q.cnt != 2'h0) ? 1 : 0));
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign in_ready  = st_q.cnt != 2'h2;
  assign out_valid = st_q.cnt != 2'h0;
  assign out_data  = st_q.mem[st_q.rd];
endmodule

// ### dv/ihop_sva.sv
// checker for the octet packer ports
module ihop_sva
  import ihop_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        start,
  input wire logic        busy,
  input wire logic        fld_ready,
  input wire logic        ip_ready,
  input wire logic        oct_valid,
  input wire logic        oct_ready,
  input wire ihop_octet_s oct,
  input wire logic        oct_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [IHOP_NUM_W-1:0] num_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // number the next handed-over octet must carry
  always_ff @(posedge clk or posedge rst)
    if (rst)
      num_q <= IHOP_NUM_RST;
    else if (oct_valid && oct_ready)
      num_q <= oct.last ? IHOP_NUM_RST : oct.num + 16'h0001;
  a_start_busy: assert property (start && !busy |=> busy)
    else $error("busy missing after start");
  a_oct_hold: assert property (oct_valid && !oct_ready |=> oct_valid && $stable(oct))
    else $error("octet changed while stalled");
  a_num_seq: assert property (oct_valid |-> oct.num == num_q)
    else $error("octet number out of sequence");
  a_first_zero: assert property (oct_valid |-> oct.first == (oct.num == 16'h0000))
    else $error("first mark wrong");
  a_strobe_busy: assert property (oct_strobe |-> busy)
    else $error("strobe outside a unit");
  a_strobe_soon: assert property ($rose(busy) |-> ##[1:8] oct_strobe)
    else $error("no strobe after start");
  a_ip_gate: assert property (ip_ready |-> busy)
    else $error("ip taken outside a unit");
  a_fld_gate: assert property (fld_ready |-> busy)
    else $error("field taken outside a unit");
  a_hdr_out: assert property ($rose(busy) |-> ##[2:20] oct_valid)
    else $error("no octet after start");
  c_stall: cover property (oct_valid && !oct_ready);
  c_last: cover property (oct_valid && oct_ready && oct.last);
  c_fld: cover property (fld_ready && busy);
endmodule

// ### dv/ihop_sink.sv
// link layer model: takes an octet one cycle in four, serialises it, adds a check trailer
module ihop_sink
  import ihop_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        oct_valid,
  output logic             oct_ready = 1'b0,
  input  wire ihop_octet_s oct
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt = 2'h0;
  logic [7:0] fcs_q = 8'h00;
  ihop_octet_s got[$];
  logic bits[$];
  logic [7:0] trl[$];
  // check field goes into the trailer octet msb first
  function automatic logic [7:0] msb_first(input logic [7:0] v);
    for (int k = 0; k < 8; k++)
      msb_first[k] = v[7 - k];
  endfunction
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      cnt <= 2'h0;
      oct_ready <= 1'b0;
      fcs_q <= 8'h00;
    end
    else
    begin
      cnt <= cnt + 2'h1;
      oct_ready <= cnt == 2'h3;
      if (oct_valid && oct_ready)
      begin
        got.push_back(oct);
        for (int k = 0; k < 8; k++)
          bits.push_back(oct.data[k]);
        fcs_q <= oct.last ? 8'h00 : fcs_q ^ oct.data;
        if (oct.last)
          trl.push_back(msb_first(fcs_q ^ oct.data));
      end
    end
endmodule

// ### dv/tb_top.sv
// testbench for the intranet header octet packer
module tb_top
  import ihop_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0, fld_valid = 1'b0, fld_last = 1'b0, ip_valid = 1'b0, ip_last = 1'b0;
  logic [3:0] version = 4'h0, msg_type = 4'h0;
  logic [7:0] hdr_len = 8'h00, tos = 8'h00, ip_data = 8'h00;
  ihop_field_s fld = '0;
  logic busy, fld_ready, ip_ready, oct_valid, oct_ready, oct_strobe;
  ihop_octet_s oct;
  int num_errors = 0, checks = 0, cycles = 0, strobes = 0;
  always #5 clk = ~clk;
  ihop_packer i_dut (.clk(clk), .rst(rst), .start(start), .version(version),
    .msg_type(msg_type), .hdr_len(hdr_len), .tos(tos), .busy(busy), .fld_valid(fld_valid),
    .fld_ready(fld_ready), .fld(fld), .fld_last(fld_last), .ip_valid(ip_valid),
    .ip_ready(ip_ready), .ip_data(ip_data), .ip_last(ip_last), .oct_valid(oct_valid),
    .oct_ready(oct_ready), .oct(oct), .oct_strobe(oct_strobe));
  ihop_sink i_sink (.clk(clk), .rst(rst), .oct_valid(oct_valid), .oct_ready(oct_ready),
    .oct(oct));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (oct_strobe === 1'b1)
      strobes++;
    if (cycles == 3000)
    begin
      num_errors++;
      end_sim();
    end
  end
  task automatic hdr(input logic [23:0] h);
    {version, msg_type, hdr_len, tos} <= h;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask
  task automatic put_fld(input logic [7:0] v, input logic [3:0] w, input logic l);
    fld <= '{value: v, width: w};
    fld_last <= l;
    fld_valid <= 1'b1;
    do @(posedge clk); while (fld_ready !== 1'b1);
    fld_valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic put_ip(input logic [7:0] d, input logic l);
    ip_data <= d;
    ip_last <= l;
    ip_valid <= 1'b1;
    do @(posedge clk); while (ip_ready !== 1'b1);
    ip_valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic expect_out(input logic [7:0] q[$]);
    int n;
    logic [7:0] x;
    logic [7:0] r;
    n = q.size();
    x = 8'h00;
    repeat (80) if (i_sink.got.size() < n) @(posedge clk);
    chk(i_sink.got.size(), n);
    foreach (q[i])
    begin
      chk(i_sink.got[i], {q[i], i[15:0], i == 0, i == n - 1});
      for (int j = 0; j < 8; j++)
        chk(i_sink.bits[8 * i + j], q[i][j]);
      x = x ^ q[i];
    end
    // trailer check octet: xor of the unit, its msb in bit 0
    for (int j = 0; j < 8; j++)
      r[j] = x[7 - j];
    chk(i_sink.trl.size(), 1);
    chk(i_sink.trl[0], r);
    chk(busy, 1'b0);
    i_sink.got.delete();
    i_sink.bits.delete();
    i_sink.trl.delete();
  endtask
  // example header, fields skipped, a second start refused mid-unit
  task automatic t_example();
    strobes = 0;
    hdr(24'h040300);
    put_fld(8'h00, 4'h0, 1'b1);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    put_ip(8'ha2, 1'b0);
    put_ip(8'h00, 1'b0);
    put_ip(8'h4c, 1'b1);
    expect_out('{8'h40, 8'h03, 8'h00, 8'ha2, 8'h00, 8'h4c});
    chk(strobes, 3);
  endtask
  // extra field spills into a padded tail octet
  task automatic t_spill();
    strobes = 0;
    hdr(24'h5aa53c);
    put_fld(8'h05, 4'h3, 1'b0);
    put_fld(8'hff, 4'h8, 1'b1);
    put_ip(8'h7e, 1'b1);
    expect_out('{8'ha5, 8'ha5, 8'h3c, 8'hfd, 8'h07, 8'h7e});
    chk(strobes, 5);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_example();
    t_spill();
    end_sim();
  end
endmodule
bind ihop_packer ihop_sva i_sva (.clk(clk), .rst(rst), .start(start), .busy(busy),
  .fld_ready(fld_ready), .ip_ready(ip_ready), .oct_valid(oct_valid),
  .oct_ready(oct_ready), .oct(oct), .oct_strobe(oct_strobe));
